// [hdl/hwj_pkg.sv]
// shared constants, types and helpers of the handwheel jog interlock
package hwj_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NGEN  = 3;
  localparam int NAX   = 32;
  localparam int AXCAP = 3;

  // ----------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] A_ENABLE   = 12'h000;
  localparam logic [11:0] A_AXSEL0   = 12'h004;
  localparam logic [11:0] A_SMOOTH0  = 12'h010;
  localparam logic [11:0] A_POS_REQ  = 12'h020;
  localparam logic [11:0] A_HOME_REQ = 12'h024;
  localparam logic [11:0] A_DONE     = 12'h028;
  localparam logic [11:0] A_TORQUE   = 12'h02c;
  localparam logic [11:0] A_ACCEPT   = 12'h030;
  localparam logic [11:0] A_JOG      = 12'h034;
  localparam logic [11:0] A_SELERR   = 12'h038;
  localparam logic [11:0] A_MINOR    = 12'h03c;
  localparam logic [11:0] A_MCODE    = 12'h040;
  localparam logic [11:0] A_TCONST0  = 12'h044;
  localparam logic [11:0] A_MAG0     = 12'h100;

  // ----------------------------------------
  // fields, reset values, limits
  // ----------------------------------------
  localparam logic [15:0] MINOR_CODE_REJ = 16'h00d6;
  localparam logic [15:0] TORQUE_DEF     = 16'h012c;
  localparam int          TQ_VALID_BIT   = 16;
  localparam logic [15:0] MAG_MIN        = 16'h0001;
  localparam logic [15:0] MAG_MAX        = 16'h2710;
  localparam logic [15:0] MAG_RST        = 16'h0001;
  localparam logic [5:0]  SMOOTH_MAX     = 6'h3b;
  localparam logic [5:0]  SMOOTH_RST     = 6'h00;
  localparam logic [31:0] AXSEL_RST      = 32'h0000_0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam real         SMOOTH_UNIT_MS  = 56.8;
  localparam real         CLK_MHZ         = 50.0;
  localparam int          SMOOTH_UNIT_CYC = int'(SMOOTH_UNIT_MS * CLK_MHZ * 1000.0);
  localparam logic [15:0] TCONST_STEP     = 16'(int'(SMOOTH_UNIT_MS * 10.0));

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {G_IDLE, G_JOG, G_DECEL} hwj_gstate_t;

  typedef struct packed {
    logic [NAX-1:0] own;
    logic [NAX-1:0] move;
    logic [NAX-1:0] grab;
    logic [NAX-1:0] minor;
    logic           sel_err;
  } hwj_gen_ev_t;

  // keeps the three lowest set bits
  function automatic logic [NAX-1:0] cap_first3(input logic [NAX-1:0] s);
    logic [1:0] n;
    cap_first3 = '0;
    n = 2'h0;
    for (int i = 0; i < NAX; i++) begin
      if (s[i] && (n < 2'(AXCAP))) begin
        cap_first3[i] = 1'b1;
        n = n + 2'h1;
      end
    end
  endfunction : cap_first3

endpackage : hwj_pkg

// [hdl/hwj_gen.sv]
// one handwheel generator: enable edge check, axis cap, jog and decel
`timescale 1ns/1ps
module hwj_gen
  import hwj_pkg::*;
(
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           nrst,
  // controls
  input  wire logic           en,
  input  wire logic           unit_tick,
  input  wire logic [NAX-1:0] axis_sel,
  input  wire logic [5:0]     smooth,
  input  wire logic [NAX-1:0] busy,
  input  wire logic [NAX-1:0] mag_ok,
  // results
  output hwj_gen_ev_t         ev
);

  hwj_gstate_t    state;
  logic           en_q;
  logic [NAX-1:0] held;
  logic [NAX-1:0] minor;
  logic           sel_err;
  logic [5:0]     cnt;

  // ----------------------------------------
  // edge evaluation
  // ----------------------------------------
  // sample at rise
  wire logic           rise    = en & ~en_q;
  wire logic [NAX-1:0] cap     = cap_first3(axis_sel);
  wire logic           none    = (cap == '0);
  wire logic [NAX-1:0] hit     = cap & busy & ~held;
  wire logic           other   = (state == G_DECEL) && (cap != held);
  wire logic           mag_bad = |(cap & ~mag_ok);
  wire logic           accept  = rise && !other && !none && (hit == '0);
  wire logic           dec_end = (state == G_DECEL) && unit_tick && (cnt == '0);

  assign ev = {held,
               (state == G_JOG) ? held : '0,
               accept ? cap : '0,
               minor,
               sel_err};

  // ----------------------------------------
  // state
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state   <= G_IDLE;
      en_q    <= 1'b0;
      held    <= '0;
      cnt     <= '0;
      minor   <= '0;
      sel_err <= 1'b0;
    end else begin
      en_q    <= en;
      minor   <= (rise && !other && !none) ? hit : '0;
      sel_err <= (rise && other) || (accept && mag_bad);
      if ((state == G_DECEL) && unit_tick && (cnt != '0)) begin
        cnt <= cnt - 6'h1;
      end
      unique case (state)
        G_IDLE: begin
        end
        G_JOG: if (!en) begin
          state <= G_DECEL;
          cnt   <= smooth;
        end
        G_DECEL: if (dec_end && !rise) begin
          state <= G_IDLE;
          held  <= '0;
        end
      endcase
      if (accept) begin
        state <= G_JOG;
        held  <= cap;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_rise_other;
    rise && other;
  endsequence

  sequence s_decel_reject;
    sel_err && (state == G_DECEL);
  endsequence

  chk_cap_three: assert property ($countones(held) <= AXCAP)
    else $error("more than three axes held");

  chk_empty_idle: assert property (rise && none && (state == G_IDLE)
    |=> (state == G_IDLE) && (held == '0))
    else $error("empty selection started a jog");

  chk_clean_rise: assert property ($rose(state == G_JOG)
    |-> $past(rise) && ($past(hit) == '0) && (held == $past(cap)))
    else $error("jog entered without a clean rise");

  chk_decel_rej: assert property (s_rise_other |=> s_decel_reject)
    else $error("reselect during decel not refused");

  chk_jog_flag: assert property ((state == G_JOG) |-> en_q)
    else $error("jog while enable flag low");

  chk_decel_cnt: assert property (cnt <= SMOOTH_MAX)
    else $error("smoothing count beyond range");

endmodule : hwj_gen

// [hdl/hwj_top.sv]
// top of the handwheel jog interlock: apb registers, generators, axis state
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// ----------------------------------------
// What this block does
// - over three axes: keep lowest three
// - no selected axis: no jog
// - jog axis holds start accept
// - jog axis refuses positioning, home starts
// - torque limit 300 % unless changed
// - rise on busy axis: error 214
// - rejected: needs new rise while clear
// - reselect during decel: refused
// - decel refusal sets error store, flag
// - smoothing constant 56.8 to 3408 ms
// - movement only while enable high
// - selection: one bit per axis, 32
// - magnification 1 to 10000, else one
// - constant is (setting plus one) x 56.8 ms
// ----------------------------------------
module hwj_top
  import hwj_pkg::*;
#(
  parameter int UNIT_CYC = SMOOTH_UNIT_CYC
)(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            nrst,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // axis side
  output logic      [NAX-1:0]  jog_axis,
  output logic      [NAX-1:0]  jog_move,
  output logic      [NAX-1:0]  start_accept,
  output logic      [NAX-1:0]  minor_error,
  output logic      [15:0]     torque_limit,
  output logic                 axis_select_error_flag
);

  // one clock domain: every check below, generate blocks included, uses these
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [NGEN-1:0] hw_enable;
  logic [NAX-1:0]  axsel [NGEN];
  logic [5:0]      smooth [NGEN];
  logic [15:0]     mag [NAX];
  logic [15:0]     eff_mag [NAX];
  logic [NAX-1:0]  pos_busy;
  logic [NGEN-1:0] axis_select_error_store;
  logic [15:0]     tq_val;
  logic            tq_valid;
  logic [15:0]     minor_code;
  logic [21:0]     div_cnt;
  logic            unit_tick;
  hwj_gen_ev_t     ev [NGEN];
  logic [NAX-1:0]  claim [NGEN+1];
  logic [NAX-1:0]  jog_all;
  logic [NAX-1:0]  move_all;
  logic [NAX-1:0]  minor_all;
  logic [NAX-1:0]  grab_all;
  logic [NGEN-1:0] sel_ev;
  logic [NAX-1:0]  mag_ok;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  function automatic logic grp_hit(input logic [11:0] off);
    grp_hit = (off[11:4] == 8'h00) && (off[1:0] == 2'h0) && (off[3:2] < 2'(NGEN));
  endfunction : grp_hit

  function automatic logic [15:0] tconst(input logic [5:0] s);
    tconst = 16'((16'(s) + 16'h0001) * TCONST_STEP);
  endfunction : tconst

  wire logic        wr_en  = psel & penable & pwrite;
  wire logic        setup  = psel & ~penable;
  wire logic [11:0] off_ax = paddr - A_AXSEL0;
  wire logic [11:0] off_sm = paddr - A_SMOOTH0;
  wire logic [11:0] off_tc = paddr - A_TCONST0;
  wire logic [11:0] off_mg = paddr - A_MAG0;
  wire logic        in_ax  = grp_hit(off_ax);
  wire logic        in_sm  = grp_hit(off_sm);
  wire logic        in_tc  = grp_hit(off_tc);
  wire logic        in_mg  = (off_mg[11:7] == 5'h00) && (off_mg[1:0] == 2'h0);
  wire logic        is_en  = (paddr == A_ENABLE);
  wire logic        is_pos = (paddr == A_POS_REQ);
  wire logic        is_hom = (paddr == A_HOME_REQ);
  wire logic        is_don = (paddr == A_DONE);
  wire logic        is_tq  = (paddr == A_TORQUE);
  wire logic        is_acc = (paddr == A_ACCEPT);
  wire logic        is_jog = (paddr == A_JOG);
  wire logic        is_sel = (paddr == A_SELERR);
  wire logic        is_min = (paddr == A_MINOR);
  wire logic        is_mc  = (paddr == A_MCODE);
  wire logic        mapped = is_en | is_pos | is_hom | is_don | is_tq | is_acc | is_jog
                           | is_sel | is_min | is_mc | in_ax | in_sm | in_tc | in_mg;
  wire logic        w_en   = wr_en && is_en;
  wire logic        w_tq   = wr_en && is_tq;
  wire logic        w_sel  = wr_en && is_sel;
  wire logic        w_min  = wr_en && is_min;
  wire logic        w_don  = wr_en && is_don;
  wire logic        w_req  = wr_en && (is_pos || is_hom);

  // ----------------------------------------
  // apb read data
  // ----------------------------------------
  // constant read back in tenths of ms
  wire logic [31:0] rd_data =
      is_en  ? 32'(hw_enable) :
      in_ax  ? axsel[off_ax[3:2]] :
      in_sm  ? 32'(smooth[off_sm[3:2]]) :
      in_tc  ? 32'(tconst(smooth[off_tc[3:2]])) :
      in_mg  ? {eff_mag[off_mg[6:2]], mag[off_mg[6:2]]} :
      is_don ? pos_busy :
      is_tq  ? {15'h0000, tq_valid, tq_val} :
      is_acc ? start_accept :
      is_jog ? jog_axis :
      is_sel ? 32'(axis_select_error_store) :
      is_min ? minor_error :
      is_mc  ? 32'(minor_code) :
      32'h0000_0000;

  // answer is prepared in the setup cycle, so every access completes at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= rd_data;
        pslverr <= ~mapped;
      end
    end
  end

  // ----------------------------------------
  // smoothing time base
  // ----------------------------------------
  // first unit of a decel may be short: the divider runs free to save a counter
  wire logic div_end = (div_cnt == 22'(UNIT_CYC - 1));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt   <= '0;
      unit_tick <= 1'b0;
    end else begin
      div_cnt   <= div_end ? '0 : div_cnt + 22'h1;
      unit_tick <= div_end;
    end
  end

  // ----------------------------------------
  // generator results merged
  // ----------------------------------------
  // lower generators win a contested axis; higher ones see it busy
  always_comb begin
    jog_all   = '0;
    move_all  = '0;
    minor_all = '0;
    grab_all  = '0;
    for (int g = 0; g < NGEN; g++) begin
      jog_all   = jog_all | ev[g].own;
      move_all  = move_all | ev[g].move;
      minor_all = minor_all | ev[g].minor;
      grab_all  = grab_all | ev[g].grab;
    end
  end

  // busy axes feed the start check
  assign claim[0] = jog_all | pos_busy;

  // ----------------------------------------
  // generators
  // ----------------------------------------
  for (genvar g = 0; g < NGEN; g++) begin : gen_hw
    wire logic       w_ax  = wr_en && in_ax && (off_ax[3:2] == 2'(g));
    wire logic       w_sm  = wr_en && in_sm && (off_sm[3:2] == 2'(g));
    wire logic [5:0] sm_in = (pwdata > 32'(SMOOTH_MAX)) ? SMOOTH_MAX : pwdata[5:0];

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        axsel[g]  <= AXSEL_RST;
        smooth[g] <= SMOOTH_RST;
      end else begin
        if (w_ax) begin
          axsel[g] <= pwdata;
        end
        if (w_sm) begin
          smooth[g] <= sm_in;
        end
      end
    end

    hwj_gen u_gen (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .en        (hw_enable[g]),
      .unit_tick (unit_tick),
      .axis_sel  (axsel[g]),
      .smooth    (smooth[g]),
      .busy      (claim[g]),
      .mag_ok    (mag_ok),
      .ev        (ev[g])
    );

    assign claim[g+1] = claim[g] | ev[g].grab;
    assign sel_ev[g]  = ev[g].sel_err;

    chk_smooth_rng: assert property (smooth[g] <= SMOOTH_MAX)
      else $error("smoothing setting above range");
  end

  // ----------------------------------------
  // per-axis magnification
  // ----------------------------------------
  for (genvar i = 0; i < NAX; i++) begin : gen_ax
    wire logic w_mg = wr_en && in_mg && (off_mg[6:2] == 5'(i));

    assign mag_ok[i] = (mag[i] >= MAG_MIN) && (mag[i] <= MAG_MAX);

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        mag[i]     <= MAG_RST;
        eff_mag[i] <= MAG_RST;
      end else begin
        if (w_mg) begin
          mag[i] <= pwdata[15:0];
        end
        if (grab_all[i]) begin
          eff_mag[i] <= mag_ok[i] ? mag[i] : MAG_MIN;
        end
      end
    end

    chk_mag_fallback: assert property (grab_all[i] && !mag_ok[i]
      |=> eff_mag[i] == MAG_MIN)
      else $error("bad magnification not replaced by one");
  end

  // ----------------------------------------
  // control and sticky status
  // ----------------------------------------
  wire logic [NAX-1:0]  start_req = w_req ? pwdata : '0;
  wire logic [NAX-1:0]  next_pos  = (pos_busy & ~(w_don ? pwdata : '0))
                                  | (start_req & ~jog_all);
  wire logic [NGEN-1:0] next_sel  =
      (axis_select_error_store & ~(w_sel ? pwdata[NGEN-1:0] : '0)) | sel_ev;
  wire logic [NAX-1:0]  next_min  = (minor_error & ~(w_min ? pwdata : '0)) | minor_all;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hw_enable               <= '0;
      pos_busy                <= '0;
      axis_select_error_store <= '0;
      minor_error             <= '0;
      minor_code              <= '0;
      tq_valid                <= 1'b0;
      tq_val                  <= TORQUE_DEF;
    end else begin
      pos_busy                <= next_pos;
      axis_select_error_store <= next_sel;
      minor_error             <= next_min;
      if (w_en) begin
        hw_enable <= pwdata[NGEN-1:0];
      end
      if (|minor_all) begin
        minor_code <= MINOR_CODE_REJ;
      end
      if (w_tq) begin
        tq_valid <= pwdata[TQ_VALID_BIT];
        tq_val   <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // axis outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      jog_axis               <= '0;
      jog_move               <= '0;
      start_accept           <= '0;
      torque_limit           <= TORQUE_DEF;
      axis_select_error_flag <= 1'b0;
    end else begin
      jog_axis               <= jog_all;
      jog_move               <= move_all;
      start_accept           <= jog_all | pos_busy;
      torque_limit           <= tq_valid ? tq_val : TORQUE_DEF;
      axis_select_error_flag <= |next_sel;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // accept covers jog
  chk_accept_held: assert property ((jog_axis & ~start_accept) == '0)
    else $error("jog axis without start accept");

  chk_start_refused: assert property (w_req
    |=> (pos_busy & ~$past(pos_busy) & $past(jog_all)) == '0)
    else $error("start accepted on a jog axis");

  chk_torque_def: assert property (!tq_valid |=> torque_limit == TORQUE_DEF)
    else $error("torque limit not at default");

  chk_minor_code: assert property (|minor_all
    |=> (minor_code == MINOR_CODE_REJ) && ((minor_error & $past(minor_all)) == $past(minor_all)))
    else $error("rejected rise did not record error 214");

  chk_sel_flag: assert property (|sel_ev
    |=> axis_select_error_flag)
    else $error("selection error flag not raised");

endmodule : hwj_top

// [tb/hwj_ctl_model.sv]
// controlling program model: apb master that raises and drops enable flags
`timescale 1ns/1ps
module hwj_ctl_model
  import hwj_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  // status
  output logic             hung
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    hung    = 1'b0;
  end
  // ----------------------------------------
  // bus cycles, entered just after an edge
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge sys_clk);
    end
    if (pready !== 1'b1) hung <= 1'b1;
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so a new setup never lands on the release edge
    @(posedge sys_clk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd
  task automatic en_if_clear(input logic [2:0] en, input logic [31:0] ax, output logic ok);
    logic [31:0] q;
    rd(A_ACCEPT, q);
    ok = ((q & ax) == 32'h0000_0000);
    if (ok) wr(A_ENABLE, {29'h0000_0000, en});
  endtask : en_if_clear
endmodule : hwj_ctl_model

// [tb/handwheel_jog_interlock_tb_top.sv]
// self-checking bench of the handwheel jog interlock
`timescale 1ns/1ps
module handwheel_jog_interlock_tb_top
  import hwj_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, sel_err, hung, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, jog_axis, jog_move, start_accept, minor_error;
  logic [15:0] torque_limit;
  logic [31:0] rdq;
  int err_count = 0;
  int n_tests = 0;

  always #10 sys_clk = ~sys_clk;

  // short smoothing unit keeps decel waits brief
  hwj_top #(.UNIT_CYC(20)) uut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .jog_axis(jog_axis),
    .jog_move(jog_move), .start_accept(start_accept), .minor_error(minor_error),
    .torque_limit(torque_limit), .axis_select_error_flag(sel_err));
  hwj_ctl_model ctl (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .hung(hung));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ctl.rd(a, q);
    chk(q, exp);
  endtask : rchk
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // decel length is set by the smoothing setting, so poll with a bound
  task automatic wait_free(input logic [31:0] m);
    int n;
    n = 0;
    while ((jog_axis & m) !== 32'h0000_0000 && n < 3000) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 3000) begin
      err_count++;
      finish_test();
    end
  endtask : wait_free
  always @(posedge hung) begin
    err_count++;
    finish_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    wt(8);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk(32'(torque_limit), 32'h0000_012c);
    ctl.rd(12'h080, rdq);
    chk(32'(pslverr), 32'h0000_0001);
    chk(rdq, 32'h0000_0000);
    // over three axes, lowest three kept
    ctl.wr(A_AXSEL0, 32'h0000_00f1);
    ctl.en_if_clear(3'h1, 32'h0000_00f1, ok);
    wt(3);
    chk(jog_axis, 32'h0000_0031);
    chk(jog_move, 32'h0000_0031);
    rchk(A_ACCEPT, 32'h0000_0031);
    ctl.wr(A_POS_REQ, 32'h0000_0101);
    ctl.wr(A_HOME_REQ, 32'h0000_0010);
    rchk(A_DONE, 32'h0000_0100);
    ctl.wr(A_DONE, 32'h0000_0100);
    rchk(A_DONE, 32'h0000_0000);
    // second generator raised on a held axis, interlock skipped on purpose
    ctl.wr(A_AXSEL0 + 12'h004, 32'h0000_0010);
    ctl.wr(A_ENABLE, 32'h0000_0003);
    wt(3);
    chk(minor_error, 32'h0000_0010);
    chk(jog_axis, 32'h0000_0031);
    rchk(A_MCODE, 32'h0000_00d6);
    ctl.wr(A_ENABLE, 32'h0000_0002);
    wt(3);
    chk(jog_move, 32'h0000_0000);
    wait_free(32'h0000_0031);
    wt(3);
    chk(jog_axis, 32'h0000_0000);
    ctl.wr(A_ENABLE, 32'h0000_0000);
    ctl.en_if_clear(3'h2, 32'h0000_0010, ok);
    wt(3);
    chk(jog_axis, 32'h0000_0010);
    ctl.wr(A_MINOR, 32'hffff_ffff);
    ctl.wr(A_ENABLE, 32'h0000_0000);
    chk(minor_error, 32'h0000_0000);
    wait_free(32'h0000_0010);
    // smoothing range, clamp and reselect during decel
    ctl.wr(A_SMOOTH0, 32'h0000_003f);
    rchk(A_SMOOTH0, 32'h0000_003b);
    rchk(A_TCONST0, 32'h0000_8520);
    rchk(A_TCONST0 + 12'h004, 32'h0000_0238);
    ctl.wr(A_AXSEL0, 32'h0000_0002);
    ctl.en_if_clear(3'h1, 32'h0000_0002, ok);
    ctl.wr(A_ENABLE, 32'h0000_0000);
    ctl.wr(A_AXSEL0, 32'h0000_0004);
    ctl.wr(A_ENABLE, 32'h0000_0001);
    wt(3);
    chk(jog_axis, 32'h0000_0002);
    chk(32'(sel_err), 32'h0000_0001);
    rchk(A_SELERR, 32'h0000_0001);
    ctl.wr(A_ENABLE, 32'h0000_0000);
    wait_free(32'h0000_0002);
    ctl.wr(A_SELERR, 32'h0000_0001);
    wt(2);
    chk(32'(sel_err), 32'h0000_0000);
    // out-of-range magnification falls back to one
    ctl.wr(A_SMOOTH0, 32'h0000_0000);
    ctl.wr(A_MAG0 + 12'h008, 32'h0000_0000);
    ctl.wr(A_ENABLE, 32'h0000_0001);
    wt(3);
    chk(jog_axis, 32'h0000_0004);
    chk(32'(sel_err), 32'h0000_0001);
    rchk(A_MAG0 + 12'h008, 32'h0001_0000);
    ctl.wr(A_ENABLE, 32'h0000_0000);
    wait_free(32'h0000_0004);
    // empty selection does nothing
    ctl.wr(A_AXSEL0, 32'h0000_0000);
    ctl.wr(A_ENABLE, 32'h0000_0001);
    wt(3);
    chk(start_accept, 32'h0000_0000);
    ctl.wr(A_TORQUE, 32'h0001_0096);
    wt(2);
    chk(32'(torque_limit), 32'h0000_0096);
    ctl.wr(A_TORQUE, 32'h0000_0096);
    wt(2);
    chk(32'(torque_limit), 32'h0000_012c);
    finish_test();
  end
endmodule : handwheel_jog_interlock_tb_top
